/* File: hdl/plec_defines.vh */
`ifndef PLEC_DEFINES_VH
`define PLEC_DEFINES_VH
// ==========================================
// register byte offsets
`define PLEC_OFF_STATUS 12'h000
`define PLEC_OFF_MASK 12'h004
`define PLEC_OFF_CTRL 12'h008
`define PLEC_OFF_CPLCFG 12'h00c
`define PLEC_OFF_CPLHDR 12'h010
`define PLEC_OFF_COUNT 12'h014
// ==========================================
// event bit positions in status and mask
`define PLEC_EV_RXPORT 0
`define PLEC_EV_BADTLP 1
`define PLEC_EV_BADDLLP 2
`define PLEC_EV_REPTMR 3
`define PLEC_EV_REPROLL 4
`define PLEC_EV_DLPROT 5
`define PLEC_NUM_EV 6
// ==========================================
// control bits
`define PLEC_CTRL_PHY_EN 0
`define PLEC_CTRL_TAG32 1
`define PLEC_CTRL_RESET 32'h0000_0001
// ==========================================
// severity codes
`define PLEC_SEV_NONE 2'h0
`define PLEC_SEV_CORR 2'h1
`define PLEC_SEV_NONFATAL 2'h2
`define PLEC_SEV_FATAL 2'h3
// ==========================================
// receive status codes and completion sizing
`define PLEC_RXS_DECODE 3'h4
`define PLEC_RXS_EBOVF 3'h5
`define PLEC_RXS_EBUNF 3'h6
`define PLEC_RXS_DISP 3'h7
`define PLEC_RCB_SHIFT 6
`define PLEC_CPL_BYTES_RESET 32'h0000_4000
`endif

/* File: hdl/plec_count_mem.v */
`timescale 1ns/1ps
// ==========================================
// per-event error counters, registered read
module plec_count_mem #(
    parameter NUM = 6,
    parameter AW = 3
) (
    input wire aclk,
    input wire aresetn,
    input wire [NUM-1:0] inc,
    input wire [AW-1:0] rd_idx,
    output reg [15:0] rd_data
);
    reg [15:0] cnt [0:NUM-1];
    genvar i;
    // one saturating counter per event
    generate
        for (i = 0; i < NUM; i = i + 1) begin : g_cnt
            always @(posedge aclk) begin
                if (!aresetn) begin
                    cnt[i] <= 16'h0000;
                end else if (inc[i] && cnt[i] != 16'hffff) begin
                    cnt[i] <= cnt[i] + 16'h0001;
                end
            end
        end
    endgenerate
    // registered read port
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_data <= 16'h0000;
        end else if (rd_idx < NUM) begin
            rd_data <= cnt[rd_idx];
        end else begin
            rd_data <= 16'h0000;
        end
    end
endmodule // plec_count_mem

/* File: hdl/plec_error_classifier.v */
`timescale 1ns/1ps
`include "plec_defines.vh"
module plec_error_classifier #(
    parameter LANES = 8
) (
    input wire aclk,
    input wire aresetn,
    // per-lane and link-wide physical inputs from the transceiver domain
    input wire [3*LANES-1:0] rx_status,
    input wire [LANES-1:0] lane_in_l0,
    input wire deskew_overflow,
    input wire ctrl_symbol_wrong_lane,
    // data link layer events, same clock
    input wire tlp_lcrc_fail,
    input wire tlp_seq_error,
    input wire dllp_crc_fail,
    input wire replay_timer_expired,
    input wire replay_count_wrap,
    input wire ack_received,
    input wire [11:0] acknowledged_sequence_number,
    input wire [11:0] oldest_unacked_seq,
    input wire [11:0] next_tx_seq,
    // error reporting outputs
    output reg err_valid,
    output reg [1:0] err_severity,
    output reg [5:0] err_events,
    output reg err_basic_corr,
    output reg err_basic_fatal,
    output reg err_adv_log,
    output reg cpl_credit_infinite,
    output reg [31:0] cpl_hdr_credits,
    output reg tag_limit_32,
    output reg irq,
    // axi4-lite slave
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    localparam NE = `PLEC_NUM_EV;
    localparam RD_IDLE = 2'h0;
    localparam RD_WAIT = 2'h1;
    localparam RD_DONE = 2'h2;

    reg [3*LANES-1:0] rxs_s1;
    reg [3*LANES-1:0] rxs_s2;
    reg [LANES-1:0] l0_s1;
    reg [LANES-1:0] l0_s2;
    reg [1:0] dsk_s;
    reg [1:0] csym_s;
    reg [NE-1:0] status;
    reg [NE-1:0] mask;
    reg [31:0] ctrl;
    reg [31:0] cpl_bytes;
    reg [1:0] rd_state;
    reg [11:0] rd_addr;
    reg [11:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;
    wire [15:0] cnt_rd;
    wire [2:0] cnt_idx;
    wire [LANES-1:0] lane_err;
    wire phy_en;
    wire rx_port_err;
    wire ack_in_window;
    wire [11:0] ack_dist;
    wire [11:0] win_len;
    wire [NE-1:0] detect;
    wire wr_fire;
    wire [31:0] wmask;
    reg [1:0] next_sev;

    // ==========================================
    // synchronisers for transceiver-side inputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            rxs_s1 <= {3*LANES{1'b0}};
            rxs_s2 <= {3*LANES{1'b0}};
            l0_s1 <= {LANES{1'b0}};
            l0_s2 <= {LANES{1'b0}};
            dsk_s <= 2'h0;
            csym_s <= 2'h0;
        end else begin
            rxs_s1 <= rx_status;
            rxs_s2 <= rxs_s1;
            l0_s1 <= lane_in_l0;
            l0_s2 <= l0_s1;
            dsk_s <= {dsk_s[0], deskew_overflow};
            csym_s <= {csym_s[0], ctrl_symbol_wrong_lane};
        end
    end

    // ==========================================
    // physical layer detection
    genvar ln;
    generate
        for (ln = 0; ln < LANES; ln = ln + 1) begin : g_lane
            // codes with msb set are all errors: decode, buffer overflow/underflow, disparity
            assign lane_err[ln] = l0_s2[ln] && rxs_s2[3*ln+2];
        end
    endgenerate
    assign phy_en = ctrl[`PLEC_CTRL_PHY_EN];
    assign rx_port_err = phy_en && ((|lane_err) || dsk_s[1] || csym_s[1]);

    // ==========================================
    // data link layer detection
    // ack must fall within oldest unacked - 1 .. next_tx - 1 (modulo 4096)
    assign win_len = next_tx_seq - oldest_unacked_seq;
    assign ack_dist = acknowledged_sequence_number - oldest_unacked_seq + 12'h001;
    assign ack_in_window = ack_dist <= win_len;
    assign detect[`PLEC_EV_RXPORT] = rx_port_err;
    assign detect[`PLEC_EV_BADTLP] = tlp_lcrc_fail || tlp_seq_error;
    assign detect[`PLEC_EV_BADDLLP] = dllp_crc_fail;
    assign detect[`PLEC_EV_REPTMR] = replay_timer_expired;
    assign detect[`PLEC_EV_REPROLL] = replay_count_wrap;
    assign detect[`PLEC_EV_DLPROT] = ack_received && !ack_in_window;

    // severity class of the detected set, fatal dominates
    always @* begin
        if (detect[`PLEC_EV_DLPROT]) begin
            next_sev = `PLEC_SEV_FATAL;
        end else if (|detect) begin
            next_sev = `PLEC_SEV_CORR;
        end else begin
            next_sev = `PLEC_SEV_NONE;
        end
    end

    // ==========================================
    // reporting outputs, one cycle after detection
    always @(posedge aclk) begin
        if (!aresetn) begin
            err_valid <= 1'b0;
            err_severity <= `PLEC_SEV_NONE;
            err_events <= 6'h00;
            err_basic_corr <= 1'b0;
            err_basic_fatal <= 1'b0;
            err_adv_log <= 1'b0;
        end else begin
            err_valid <= |detect;
            err_severity <= next_sev;
            err_events <= detect;
            // basic signalling per class plus advanced log strobe
            err_basic_corr <= |detect[`PLEC_EV_REPROLL:`PLEC_EV_RXPORT];
            err_basic_fatal <= detect[`PLEC_EV_DLPROT];
            err_adv_log <= |detect;
        end
    end

    // ==========================================
    // completion credit and tag outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            cpl_credit_infinite <= 1'b0;
            cpl_hdr_credits <= 32'h0000_0000;
            tag_limit_32 <= 1'b0;
        end else begin
            cpl_credit_infinite <= 1'b1;
            cpl_hdr_credits <= cpl_bytes >> `PLEC_RCB_SHIFT;
            tag_limit_32 <= ctrl[`PLEC_CTRL_TAG32];
        end
    end

    // ==========================================
    // axi4-lite write path
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            mask <= {NE{1'b0}};
            ctrl <= `PLEC_CTRL_RESET;
            cpl_bytes <= `PLEC_CPL_BYTES_RESET;
        end else begin
            // accept address and data in either order
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (aw_addr)
                    `PLEC_OFF_STATUS: begin
                    end
                    `PLEC_OFF_MASK: begin
                        mask <= (mask & ~wmask[NE-1:0]) | (w_data[NE-1:0] & wmask[NE-1:0]);
                    end
                    `PLEC_OFF_CTRL: begin
                        ctrl <= (ctrl & ~wmask) | (w_data & wmask & 32'h0000_0003);
                    end
                    `PLEC_OFF_CPLCFG: begin
                        cpl_bytes <= (cpl_bytes & ~wmask) | (w_data & wmask);
                    end
                    default: begin
                        s_axi_bresp <= 2'h2; // unmapped or read-only
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================
    // sticky status, set wins over write-one-to-clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            status <= {NE{1'b0}};
            irq <= 1'b0;
        end else begin
            if (wr_fire && aw_addr == `PLEC_OFF_STATUS) begin
                status <= (status & ~(w_data[NE-1:0] & wmask[NE-1:0])) | detect;
            end else begin
                status <= status | detect;
            end
            irq <= |(status & mask);
        end
    end

    // ==========================================
    // axi4-lite read path, two cycles to allow counter read
    // counter index follows the bus address while idle, so data is ready in RD_WAIT
    assign cnt_idx = (rd_state == RD_IDLE) ? s_axi_araddr[4:2] : rd_addr[4:2];
    plec_count_mem #(
        .NUM(NE),
        .AW(3)
    ) u_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .inc(detect),
        .rd_idx(cnt_idx),
        .rd_data(cnt_rd)
    );
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= RD_IDLE;
            rd_addr <= 12'h000;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            case (rd_state)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_addr <= s_axi_araddr;
                        s_axi_arready <= 1'b0;
                        rd_state <= RD_WAIT;
                    end
                end
                RD_WAIT: begin
                    s_axi_rvalid <= 1'b1;
                    s_axi_rresp <= 2'h0;
                    rd_state <= RD_DONE;
                    case (rd_addr[11:5])
                        7'h00: begin
                            case (rd_addr[4:0])
                                5'h00: s_axi_rdata <= {26'h0, status};
                                5'h04: s_axi_rdata <= {26'h0, mask};
                                5'h08: s_axi_rdata <= ctrl;
                                5'h0c: s_axi_rdata <= cpl_bytes;
                                5'h10: s_axi_rdata <= cpl_hdr_credits;
                                default: begin
                                    s_axi_rdata <= 32'h0000_0000;
                                    s_axi_rresp <= 2'h2;
                                end
                            endcase
                        end
                        7'h01: begin
                            // counters at 0x020 + 4*event
                            s_axi_rdata <= {16'h0000, cnt_rd};
                        end
                        default: begin
                            s_axi_rdata <= 32'h0000_0000;
                            s_axi_rresp <= 2'h2;
                        end
                    endcase
                end
                RD_DONE: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rd_state <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= RD_IDLE;
                end
            endcase
        end
    end
endmodule // plec_error_classifier

/* File: tb/plec_sva.sv */
`timescale 1ns/1ps
// ==========================================
// classifier output checker
module plec_sva (
    input wire aclk,
    input wire aresetn,
    input wire tlp_lcrc_fail,
    input wire tlp_seq_error,
    input wire dllp_crc_fail,
    input wire replay_timer_expired,
    input wire replay_count_wrap,
    input wire err_valid,
    input wire [1:0] err_severity,
    input wire [5:0] err_events,
    input wire err_adv_log,
    input wire cpl_credit_infinite
);
    // single domain, sync reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // link-layer events flagged one cycle later
    bad_tlp_a: assert property ((tlp_lcrc_fail || tlp_seq_error) |=> err_valid && err_events[1])
        else $error("bad tlp not flagged");
    bad_dllp_a: assert property (dllp_crc_fail |=> err_valid && err_events[2])
        else $error("bad dllp not flagged");
    replay_timer_a: assert property (replay_timer_expired |=> err_valid && err_events[3])
        else $error("replay timeout not flagged");
    replay_roll_a: assert property (replay_count_wrap |=> err_valid && err_events[4])
        else $error("replay rollover not flagged");
    // severity follows the event class
    corr_severity_a: assert property (err_valid && !err_events[5] |-> err_severity == 2'h1)
        else $error("correctable severity wrong");
    fatal_severity_a: assert property (err_valid && err_events[5] |-> err_severity == 2'h3)
        else $error("fatal severity wrong");
    valid_logged_a: assert property (err_valid |-> err_events != 6'h0 && err_adv_log)
        else $error("pulse without cause or log");
    credit_inf_a: assert property ($past(aresetn) |-> cpl_credit_infinite)
        else $error("completion credits not infinite");
endmodule // plec_sva
bind plec_error_classifier plec_sva u_chk (.aclk, .aresetn, .tlp_lcrc_fail, .tlp_seq_error,
    .dllp_crc_fail, .replay_timer_expired, .replay_count_wrap, .err_valid, .err_severity,
    .err_events, .err_adv_log, .cpl_credit_infinite);

/* File: tb/plec_link_model.sv */
`timescale 1ns/1ps
// ==========================================
// transceiver and link partner event source
module plec_link_model (
    input wire aclk,
    output logic [23:0] rx_status = 24'h0,
    output logic [7:0] lane_in_l0 = 8'hff,
    output logic [6:0] ev = 7'h0,
    output logic ack_received = 1'b0,
    output logic [11:0] acknowledged_sequence_number = 12'h0,
    output logic [11:0] oldest_unacked_seq = 12'hffe,
    output logic [11:0] next_tx_seq = 12'h003
);
    // one lane reports a status code, the rest stay clean
    task rxs(input int l, input logic [2:0] c, input logic l0);
        @(posedge aclk);
        rx_status <= 24'(c) << (3 * l);
        lane_in_l0 <= {8{l0}};
    endtask
    // one-cycle pulse on event line k
    task pulse(input int k);
        @(posedge aclk);
        ev <= 7'(1) << k;
        @(posedge aclk);
        ev <= 7'h0;
    endtask
    // ack pulse, number scrambled once released
    task ack(input logic [11:0] s);
        @(posedge aclk);
        ack_received <= 1'b1;
        acknowledged_sequence_number <= s;
        @(posedge aclk);
        ack_received <= 1'b0;
        acknowledged_sequence_number <= ~s;
    endtask
    // move the window of unacknowledged tlps
    task win(input logic [11:0] o, input logic [11:0] n);
        @(posedge aclk);
        oldest_unacked_seq <= o;
        next_tx_seq <= n;
    endtask
endmodule // plec_link_model

/* File: tb/pcie_link_error_classifier_test.sv */
`timescale 1ns/1ps
`include "plec_defines.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module pcie_link_error_classifier_test;
    logic aclk = 0, aresetn = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] acc_basic = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, err_valid, err_basic_corr, err_basic_fatal, err_adv_log;
    logic cpl_credit_infinite, tag_limit_32, irq, ack_received;
    logic [1:0] s_axi_bresp, s_axi_rresp, err_severity, acc_sev = 0;
    logic [31:0] s_axi_rdata, cpl_hdr_credits, seed = 32'hd1cfd80c;
    logic [5:0] err_events, acc_ev = 0;
    logic [23:0] rx_status;
    logic [7:0] lane_in_l0;
    logic [6:0] ev;
    logic [11:0] acknowledged_sequence_number, oldest_unacked_seq, next_tx_seq;
    int num_errors = 0, compares = 0, k;
    // ==========================================
    // clock, design, partner
    initial forever #25 aclk = ~aclk;
    plec_error_classifier #(.LANES(8)) DUT (.aclk, .aresetn, .rx_status, .lane_in_l0,
        .deskew_overflow(ev[5]), .ctrl_symbol_wrong_lane(ev[6]), .tlp_lcrc_fail(ev[0]),
        .tlp_seq_error(ev[1]), .dllp_crc_fail(ev[2]), .replay_timer_expired(ev[3]),
        .replay_count_wrap(ev[4]), .ack_received, .acknowledged_sequence_number,
        .oldest_unacked_seq, .next_tx_seq, .err_valid, .err_severity, .err_events,
        .err_basic_corr, .err_basic_fatal, .err_adv_log, .cpl_credit_infinite,
        .cpl_hdr_credits, .tag_limit_32, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    plec_link_model link (.aclk, .rx_status, .lane_in_l0, .ev, .ack_received,
        .acknowledged_sequence_number, .oldest_unacked_seq, .next_tx_seq);
    // gather every reported event and severity
    always @(posedge aclk) if (err_valid) begin
        acc_ev <= acc_ev | err_events;
        acc_sev <= acc_sev | err_severity;
        acc_basic <= acc_basic | {err_basic_fatal, err_basic_corr};
    end
    // ==========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // status bit expected for event line k
    function automatic logic [5:0] ev_bit(input int k);
        return 6'h1 << (k < 2 ? 1 : (k < 5 ? k : 0));
    endfunction
    task end_sim;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one register access, write when w is set
    task axi(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
        end
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
        s_axi_bready <= 0;
        s_axi_rready <= 0;
        if (n >= 40) begin
            num_errors++;
            end_sim();
        end
        if (w) `CHK(s_axi_bresp, er)
        else begin
            `CHK(s_axi_rresp, er)
            `CHK(s_axi_rdata, d)
        end
    endtask
    // hold a lane code, then see if a receive error came out
    task phy(input int l, input logic [2:0] c, input logic l0, input logic e);
        acc_ev = 0;
        link.rxs(l, c, l0);
        repeat (8) @(posedge aclk);
        link.rxs(0, 3'h0, 1);
        repeat (8) @(posedge aclk);
        `CHK(acc_ev[0], e)
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        axi(0, `PLEC_OFF_CTRL, `PLEC_CTRL_RESET, 2'h0);
        axi(0, `PLEC_OFF_CPLHDR, 32'h100, 2'h0);
        axi(0, 12'h100, 32'h0, 2'h2);
        axi(1, `PLEC_OFF_CPLHDR, 32'h1, 2'h2);
        `CHK(cpl_credit_infinite, 1'b1)
        $display("test reset done");
        axi(1, `PLEC_OFF_MASK, 32'h3f, 2'h0);
        for (k = 0; k < 7; k++) begin
            acc_ev = 0;
            acc_sev = 0;
            acc_basic = 0;
            link.pulse(k);
            repeat (8) @(posedge aclk);
            `CHK(acc_ev, ev_bit(k))
            `CHK(acc_sev, 2'h1)
            `CHK(acc_basic, 2'h1)
            `CHK(irq, 1'b1)
            axi(0, `PLEC_OFF_STATUS, 32'(ev_bit(k)), 2'h0);
            axi(1, `PLEC_OFF_STATUS, 32'h3f, 2'h0);
            axi(0, `PLEC_OFF_STATUS, 32'h0, 2'h0);
            `CHK(irq, 1'b0)
        end
        axi(0, 12'h024, 32'h2, 2'h0);
        axi(0, 12'h02c, 32'h1, 2'h0);
        axi(1, `PLEC_OFF_MASK, 32'h0, 2'h0);
        link.pulse(2);
        repeat (8) @(posedge aclk);
        `CHK(irq, 1'b0)
        $display("test link events done");
        for (k = 0; k < 8; k++) phy(rnd() % 8, 3'(k), 1, k >= 4);
        phy(3, 3'h4, 0, 0);
        axi(1, `PLEC_OFF_CTRL, 32'h2, 2'h0);
        @(posedge aclk);
        `CHK(tag_limit_32, 1'b1)
        phy(5, 3'h7, 1, 0);
        axi(1, `PLEC_OFF_CTRL, 32'h1, 2'h0);
        @(posedge aclk);
        `CHK(tag_limit_32, 1'b0)
        $display("test receive status done");
        acc_ev = 0;
        acc_sev = 0;
        acc_basic = 0;
        link.ack(12'h001);
        link.ack(12'hffd);
        repeat (8) @(posedge aclk);
        `CHK(acc_ev, 6'h0)
        link.ack(12'h005);
        repeat (8) @(posedge aclk);
        `CHK(acc_ev, 6'h20)
        `CHK(acc_sev, 2'h3)
        `CHK(acc_basic, 2'h2)
        // empty window: only the ack of oldest - 1 is legal
        acc_ev = 0;
        link.win(12'h010, 12'h010);
        link.ack(12'h00f);
        repeat (8) @(posedge aclk);
        `CHK(acc_ev, 6'h0)
        link.ack(12'h010);
        repeat (8) @(posedge aclk);
        `CHK(acc_ev, 6'h20)
        $display("test ack window done");
        for (k = 0; k < 4; k++) begin
            v = rnd() & 32'h000fffff;
            axi(1, `PLEC_OFF_CPLCFG, v, 2'h0);
            axi(0, `PLEC_OFF_CPLHDR, v >> 6, 2'h0);
            `CHK(cpl_hdr_credits, v >> 6)
        end
        // byte strobes: only byte 1 of the buffer size changes
        s_axi_wstrb <= 4'h2;
        axi(1, `PLEC_OFF_CPLCFG, 32'hffff_ffff, 2'h0);
        s_axi_wstrb <= 4'hf;
        axi(0, `PLEC_OFF_CPLCFG, (v & 32'hffff_00ff) | 32'h0000_ff00, 2'h0);
        axi(0, `PLEC_OFF_CPLHDR, ((v & 32'hffff_00ff) | 32'h0000_ff00) >> 6, 2'h0);
        $display("test credits done");
        end_sim();
    end
endmodule // pcie_link_error_classifier_test
